// ==== verilog/mer_regs.sv ====
// Notes on behaviour
// (R1) The low message address keeps bits 31:2 writable from a zero reset and reads 1:0 as zero.
// (R2) The high message address is a full 32-bit writable word resetting to zero.
// (R3) Message data keeps a 16-bit writable value from zero with bits 31:16 reading zero.
// (R4) The capability header reads a fixed identifier of 0001h in bits 15:0.
// (R5) The capability header reads a fixed version of 1h in bits 19:16.
// (R6) The capability header reads a fixed next link of 150h in bits 31:20.
// (R7) Uncorrectable flags at bits 0, 4 and 12 to 20 are sticky and cleared by writing one.
// (R8) Uncorrectable mask bits are sticky read-write at the flag positions, reset zero.
// (R9) Uncorrectable severity resets fatal at 0, 4, 13, 17, 18 and non-fatal elsewhere.
// (R10) Correctable flags at bits 0, 6 to 8, 12 and 13 are sticky and cleared by writing one.
// (R11) Correctable mask bits are sticky read-write, reset zero except bit 13 which resets one.
// (R12) Sticky flags, masks and severities survive a hot reset and clear only at power-on.
// (R13) An error always sets its flag; the mask only stops the report, severity picks its class.
`timescale 1ns/1ns
`default_nettype none
module mer_regs
    import mer_pkg::*;
(
    // clock and power-on reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // link or hot reset, synchronous, active high
    input wire logic hot_rst,
    // error detection pulses from link and transaction layers
    input wire logic [31:0] unc_err_evt,
    input wire logic [31:0] cor_err_evt,
    // interrupt message setup
    output logic [63:0] msg_addr,
    output logic [15:0] msg_data,
    // error reporting pulses
    output logic rpt_fatal,
    output logic rpt_nonfatal,
    output logic rpt_corr
);
    mer_phase_e phase_reg, phase_next;
    logic [11:0] addr_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] msg_lo_reg, msg_hi_reg, msg_dat_reg;

    mer_err_if eif ();

    // every check runs on the bus clock and sleeps through power-on reset
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a == off);
    endfunction

    // address phase
    wire logic accept = hsel & htrans[1] & hready;
    wire logic word_ok = (hsize == MER_HSIZE_WORD);
    wire logic acc_wr = accept & hwrite & word_ok;
    wire logic acc_rd = accept & ~hwrite;

    // data phase write strobes
    wire logic wr_act = (phase_reg == MER_PH_WRITE);
    wire logic wr_lo = wr_act & hit(addr_reg, MER_OFF_MSG_ADDR_LO);
    wire logic wr_hi = wr_act & hit(addr_reg, MER_OFF_MSG_ADDR_HI);
    wire logic wr_dat = wr_act & hit(addr_reg, MER_OFF_MSG_DATA);

    wire logic [31:0] cap_hdr = {MER_CAP_NEXT, MER_CAP_VER, MER_CAP_ID}; // R4 R5 R6

    // read selection; unmapped offsets read zero
    wire logic [31:0] rd_mux =
        hit(addr_reg, MER_OFF_MSG_ADDR_LO) ? (msg_lo_reg & MER_MSG_ADDR_LO_WMASK) :
        hit(addr_reg, MER_OFF_MSG_ADDR_HI) ? msg_hi_reg :
        hit(addr_reg, MER_OFF_MSG_DATA) ? (msg_dat_reg & MER_MSG_DATA_WMASK) :
        hit(addr_reg, MER_OFF_CAP_HDR) ? cap_hdr :
        hit(addr_reg, MER_OFF_UNC_STS) ? eif.unc_sts :
        hit(addr_reg, MER_OFF_UNC_MSK) ? eif.unc_msk :
        hit(addr_reg, MER_OFF_UNC_SEV) ? eif.unc_sev :
        hit(addr_reg, MER_OFF_COR_STS) ? eif.cor_sts :
        hit(addr_reg, MER_OFF_COR_MSK) ? eif.cor_msk : MER_ZERO;

    // one wait state on reads so a write just before is always seen
    always_comb begin
        phase_next = MER_PH_IDLE;
        unique case (phase_reg)
            MER_PH_RDWAIT: phase_next = MER_PH_RDDONE;
            MER_PH_IDLE, MER_PH_WRITE, MER_PH_RDDONE: begin
                if (acc_wr) begin
                    phase_next = MER_PH_WRITE;
                end else if (acc_rd) begin
                    phase_next = MER_PH_RDWAIT;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phase_reg <= MER_PH_IDLE;
            addr_reg <= 12'h000;
            hrdata_reg <= MER_ZERO;
        end else begin
            phase_reg <= phase_next;
            if (accept) begin
                addr_reg <= haddr[11:0];
            end
            if (phase_reg == MER_PH_RDWAIT) begin
                hrdata_reg <= rd_mux;
            end
        end
    end

    // message registers are not sticky: hot reset clears them too
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            msg_lo_reg <= MER_MSG_RST;
            msg_hi_reg <= MER_MSG_RST;
            msg_dat_reg <= MER_MSG_RST;
        end else if (hot_rst) begin
            msg_lo_reg <= MER_MSG_RST;
            msg_hi_reg <= MER_MSG_RST;
            msg_dat_reg <= MER_MSG_RST;
        end else begin
            if (wr_lo) begin
                msg_lo_reg <= hwdata & MER_MSG_ADDR_LO_WMASK; // R1
            end
            if (wr_hi) begin
                msg_hi_reg <= hwdata & MER_MSG_ADDR_HI_WMASK; // R2
            end
            if (wr_dat) begin
                msg_dat_reg <= hwdata & MER_MSG_DATA_WMASK; // R3
            end
        end
    end

    assign eif.wdata = hwdata;
    assign eif.wr_unc_sts = wr_act & hit(addr_reg, MER_OFF_UNC_STS); // R7
    assign eif.wr_unc_msk = wr_act & hit(addr_reg, MER_OFF_UNC_MSK); // R8
    assign eif.wr_unc_sev = wr_act & hit(addr_reg, MER_OFF_UNC_SEV); // R9
    assign eif.wr_cor_sts = wr_act & hit(addr_reg, MER_OFF_COR_STS); // R10
    assign eif.wr_cor_msk = wr_act & hit(addr_reg, MER_OFF_COR_MSK); // R11

    mer_err_bank u_bank (
        .hclk(hclk),
        .hresetn(hresetn),
        .unc_err_evt(unc_err_evt),
        .cor_err_evt(cor_err_evt),
        .rb(eif.bank),
        .rpt_fatal(rpt_fatal),
        .rpt_nonfatal(rpt_nonfatal),
        .rpt_corr(rpt_corr)
    );

    assign hreadyout = (phase_reg != MER_PH_RDWAIT);
    assign hresp = 1'b0;
    assign hrdata = hrdata_reg;
    assign msg_addr = {msg_hi_reg, msg_lo_reg & MER_MSG_ADDR_LO_WMASK};
    assign msg_data = msg_dat_reg[15:0];

    // checks
    wire logic rd_done = (phase_reg == MER_PH_RDDONE);

    chk_addr_low_bits: assert property ( // R1
        msg_addr[1:0] == 2'b00 && (!rd_done || !hit(addr_reg, MER_OFF_MSG_ADDR_LO)
            || hrdata[1:0] == 2'b00))
        else $error("message address low bits not zero");

    chk_addr_hi_write: assert property ( // R2
        (wr_hi && !hot_rst) |=> (msg_addr[63:32] == $past(hwdata)))
        else $error("upper message address did not take write");

    chk_data_upper_zero: assert property ( // R3
        (wr_dat && !hot_rst) |=> (msg_data == $past(hwdata[15:0]))
            && (rd_mux[31:16] == 16'h0000 || !hit(addr_reg, MER_OFF_MSG_DATA)))
        else $error("message data wrong or upper half not zero");

    chk_cap_header: assert property ( // R4 R5 R6
        (rd_done && hit(addr_reg, MER_OFF_CAP_HDR)) |->
            (hrdata[15:0] == 16'h0001 && hrdata[19:16] == 4'h1 && hrdata[31:20] == 12'h150))
        else $error("capability header read wrong");

    chk_unc_set_wins: assert property ( // R7 R13
        (|(unc_err_evt & MER_UNC_IMPL)) |=> ((eif.unc_sts & $past(unc_err_evt & MER_UNC_IMPL))
            == $past(unc_err_evt & MER_UNC_IMPL)))
        else $error("uncorrectable event lost");

    chk_unc_w1c: assert property ( // R7
        (eif.wr_unc_sts && unc_err_evt == MER_ZERO) |=>
            (eif.unc_sts == ($past(eif.unc_sts) & ~$past(hwdata))))
        else $error("uncorrectable clear wrong");

    chk_unc_reserved: assert property ( // R7 R8 R9
        ((eif.unc_sts | eif.unc_msk | eif.unc_sev) & ~MER_UNC_IMPL) == MER_ZERO)
        else $error("uncorrectable reserved bit set");

    chk_cor_set_wins: assert property ( // R10
        (|(cor_err_evt & MER_COR_IMPL)) |=> ((eif.cor_sts & $past(cor_err_evt & MER_COR_IMPL))
            == $past(cor_err_evt & MER_COR_IMPL)) && ((eif.cor_sts & ~MER_COR_IMPL) == MER_ZERO))
        else $error("correctable event lost");

    chk_cor_mask_write: assert property ( // R11
        eif.wr_cor_msk |=> (eif.cor_msk == ($past(hwdata) & MER_COR_IMPL)))
        else $error("correctable mask write wrong");

    chk_sticky_hot: assert property ( // R12
        (hot_rst && !eif.wr_unc_sev && !eif.wr_unc_msk) |=>
            (eif.unc_sev == $past(eif.unc_sev) && eif.unc_msk == $past(eif.unc_msk)
            && msg_addr == 64'h0000_0000_0000_0000))
        else $error("hot reset disturbed sticky bits or missed message");

    chk_fatal_report: assert property ( // R13
        (|(unc_err_evt & MER_UNC_IMPL & ~eif.unc_msk & eif.unc_sev)) |=> rpt_fatal)
        else $error("fatal error not reported");

    chk_mask_quiet: assert property ( // R13
        ((unc_err_evt & MER_UNC_IMPL & ~eif.unc_msk) == MER_ZERO) |=> !rpt_fatal && !rpt_nonfatal)
        else $error("masked error reported");

    chk_read_wait: assert property (
        (acc_rd && hreadyout) |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    chk_write_no_wait: assert property (
        (acc_wr && hreadyout) |=> hreadyout)
        else $error("write data phase stalled");

    chk_okay_only: assert property (
        hresp == 1'b0)
        else $error("error response driven");

    // read data is loaded once, in the wait state, and then left alone
    chk_rd_load: assert property (
        (phase_reg == MER_PH_RDWAIT) |=> (hrdata == $past(rd_mux)))
        else $error("read data not loaded in wait state");

    chk_rd_hold: assert property (
        (phase_reg != MER_PH_RDWAIT) |=> $stable(hrdata))
        else $error("read data moved outside a read");

    chk_short_write: assert property (
        (accept && hwrite && !word_ok) |=> !wr_act)
        else $error("sub-word write was taken");

    chk_addr_lo_write: assert property ( // R1
        (wr_lo && !hot_rst) |=> (msg_addr[31:2] == $past(hwdata[31:2])))
        else $error("message address did not take write");

    chk_msg_hold: assert property ( // R1 R2 R3
        (!wr_lo && !wr_hi && !wr_dat && !hot_rst) |=> ($stable(msg_addr) && $stable(msg_data)))
        else $error("message setup changed without a write");

    chk_hot_payload: assert property (
        hot_rst |=> (msg_data == 16'h0000))
        else $error("hot reset left message payload");

    chk_unc_mask_write: assert property ( // R8
        eif.wr_unc_msk |=> (eif.unc_msk == ($past(hwdata) & MER_UNC_IMPL)))
        else $error("uncorrectable mask write wrong");

    chk_unc_sev_write: assert property ( // R9
        eif.wr_unc_sev |=> (eif.unc_sev == ($past(hwdata) & MER_UNC_IMPL)))
        else $error("uncorrectable severity write wrong");

    // a flag may only move on a clear or a new event
    chk_unc_hold: assert property ( // R7 R12
        (!eif.wr_unc_sts && unc_err_evt == MER_ZERO) |=> $stable(eif.unc_sts))
        else $error("uncorrectable flag moved by itself");

    chk_cor_hold: assert property ( // R10 R12
        (!eif.wr_cor_sts && cor_err_evt == MER_ZERO) |=> $stable(eif.cor_sts))
        else $error("correctable flag moved by itself");

    chk_cor_w1c: assert property ( // R10
        (eif.wr_cor_sts && cor_err_evt == MER_ZERO) |=>
            (eif.cor_sts == ($past(eif.cor_sts) & ~$past(hwdata))))
        else $error("correctable clear wrong");

    chk_cor_reserved: assert property ( // R10 R11
        ((eif.cor_sts | eif.cor_msk) & ~MER_COR_IMPL) == MER_ZERO)
        else $error("correctable reserved bit set");

    chk_nonfatal_report: assert property ( // R13
        (|(unc_err_evt & MER_UNC_IMPL & ~eif.unc_msk & ~eif.unc_sev)) |=> rpt_nonfatal)
        else $error("non-fatal error not reported");

    chk_corr_report: assert property ( // R13
        (|(cor_err_evt & MER_COR_IMPL & ~eif.cor_msk)) |=> rpt_corr)
        else $error("correctable error not reported");

    // the report follows the mask, never the flag
    chk_corr_quiet: assert property ( // R11 R13
        ((cor_err_evt & MER_COR_IMPL & ~eif.cor_msk) == MER_ZERO) |=> !rpt_corr)
        else $error("masked correctable error reported");

    chk_fatal_class: assert property ( // R13
        rpt_fatal |-> $past(|(unc_err_evt & MER_UNC_IMPL & ~eif.unc_msk & eif.unc_sev)))
        else $error("fatal report without a fatal error");

    chk_corr_class: assert property ( // R13
        rpt_corr |-> $past(|(cor_err_evt & MER_COR_IMPL & ~eif.cor_msk)))
        else $error("correctable report without an error");
endmodule
`default_nettype wire

// ==== inc/mer_pkg.sv ====
package mer_pkg;
    // byte offsets inside configuration space
    localparam logic [11:0] MER_OFF_MSG_ADDR_LO = 12'h0f4;
    localparam logic [11:0] MER_OFF_MSG_ADDR_HI = 12'h0f8;
    localparam logic [11:0] MER_OFF_MSG_DATA = 12'h0fc;
    localparam logic [11:0] MER_OFF_CAP_HDR = 12'h100;
    localparam logic [11:0] MER_OFF_UNC_STS = 12'h104;
    localparam logic [11:0] MER_OFF_UNC_MSK = 12'h108;
    localparam logic [11:0] MER_OFF_UNC_SEV = 12'h10c;
    localparam logic [11:0] MER_OFF_COR_STS = 12'h110;
    localparam logic [11:0] MER_OFF_COR_MSK = 12'h114;

    // interrupt message fields
    localparam logic [31:0] MER_MSG_ADDR_LO_WMASK = 32'hffff_fffc;
    localparam logic [31:0] MER_MSG_ADDR_HI_WMASK = 32'hffff_ffff;
    localparam logic [31:0] MER_MSG_DATA_WMASK = 32'h0000_ffff;
    localparam logic [31:0] MER_MSG_RST = 32'h0000_0000;

    // capability header fields
    localparam logic [15:0] MER_CAP_ID = 16'h0001;
    localparam logic [3:0] MER_CAP_VER = 4'h1;
    localparam logic [11:0] MER_CAP_NEXT = 12'h150;

    // error register layouts and reset values
    localparam logic [31:0] MER_UNC_IMPL = 32'h001f_f011;
    localparam logic [31:0] MER_UNC_STS_RST = 32'h0000_0000;
    localparam logic [31:0] MER_UNC_MSK_RST = 32'h0000_0000;
    localparam logic [31:0] MER_UNC_SEV_RST = 32'h0006_2011;
    localparam logic [31:0] MER_COR_IMPL = 32'h0000_31c1;
    localparam logic [31:0] MER_COR_STS_RST = 32'h0000_0000;
    localparam logic [31:0] MER_COR_MSK_RST = 32'h0000_2000;

    // ahb encodings
    localparam logic [2:0] MER_HSIZE_WORD = 3'b010;
    localparam logic [31:0] MER_ZERO = 32'h0000_0000;

    typedef enum logic [1:0] {
        MER_PH_IDLE,
        MER_PH_WRITE,
        MER_PH_RDWAIT,
        MER_PH_RDDONE
    } mer_phase_e;
endpackage

// ==== inc/mer_err_if.sv ====
`timescale 1ns/1ns
`default_nettype none
interface mer_err_if;
    logic [31:0] wdata;
    logic wr_unc_sts;
    logic wr_unc_msk;
    logic wr_unc_sev;
    logic wr_cor_sts;
    logic wr_cor_msk;
    logic [31:0] unc_sts;
    logic [31:0] unc_msk;
    logic [31:0] unc_sev;
    logic [31:0] cor_sts;
    logic [31:0] cor_msk;

    modport bank (
        input wdata, wr_unc_sts, wr_unc_msk, wr_unc_sev, wr_cor_sts, wr_cor_msk,
        output unc_sts, unc_msk, unc_sev, cor_sts, cor_msk
    );
    modport ctrl (
        output wdata, wr_unc_sts, wr_unc_msk, wr_unc_sev, wr_cor_sts, wr_cor_msk,
        input unc_sts, unc_msk, unc_sev, cor_sts, cor_msk
    );
endinterface
`default_nettype wire

// ==== verilog/mer_err_bank.sv ====
`timescale 1ns/1ns
`default_nettype none
module mer_err_bank
    import mer_pkg::*;
(
    // clock and power-on reset only; link resets never reach here
    input wire logic hclk,
    input wire logic hresetn,
    // detected error pulses
    input wire logic [31:0] unc_err_evt,
    input wire logic [31:0] cor_err_evt,
    // register side
    mer_err_if.bank rb,
    // reporting
    output logic rpt_fatal,
    output logic rpt_nonfatal,
    output logic rpt_corr
);
    logic [31:0] unc_sts_reg, unc_sts_next;
    logic [31:0] unc_msk_reg, unc_msk_next;
    logic [31:0] unc_sev_reg, unc_sev_next;
    logic [31:0] cor_sts_reg, cor_sts_next;
    logic [31:0] cor_msk_reg, cor_msk_next;
    logic rpt_fatal_reg, rpt_nonfatal_reg, rpt_corr_reg;
    wire logic [31:0] unc_hit = unc_err_evt & MER_UNC_IMPL;
    wire logic [31:0] cor_hit = cor_err_evt & MER_COR_IMPL;
    wire logic [31:0] unc_w1c = rb.wr_unc_sts ? rb.wdata : MER_ZERO;
    wire logic [31:0] cor_w1c = rb.wr_cor_sts ? rb.wdata : MER_ZERO;
    wire logic [31:0] unc_live = unc_hit & ~unc_msk_reg;
    wire logic [31:0] cor_live = cor_hit & ~cor_msk_reg;

    // new events beat a same-cycle clear; flags set whatever the mask says
    assign unc_sts_next = ((unc_sts_reg & ~unc_w1c) | unc_hit) & MER_UNC_IMPL; // R7 R13
    assign cor_sts_next = ((cor_sts_reg & ~cor_w1c) | cor_hit) & MER_COR_IMPL; // R10 R13
    assign unc_msk_next = rb.wr_unc_msk ? (rb.wdata & MER_UNC_IMPL) : unc_msk_reg; // R8
    assign unc_sev_next = rb.wr_unc_sev ? (rb.wdata & MER_UNC_IMPL) : unc_sev_reg; // R9
    assign cor_msk_next = rb.wr_cor_msk ? (rb.wdata & MER_COR_IMPL) : cor_msk_reg; // R11

    // sticky: only the power-on reset clears these
    always_ff @(posedge hclk or negedge hresetn) begin // R12
        if (!hresetn) begin
            unc_sts_reg <= MER_UNC_STS_RST;
            unc_msk_reg <= MER_UNC_MSK_RST;
            unc_sev_reg <= MER_UNC_SEV_RST;
            cor_sts_reg <= MER_COR_STS_RST;
            cor_msk_reg <= MER_COR_MSK_RST;
            rpt_fatal_reg <= 1'b0;
            rpt_nonfatal_reg <= 1'b0;
            rpt_corr_reg <= 1'b0;
        end else begin
            unc_sts_reg <= unc_sts_next;
            unc_msk_reg <= unc_msk_next;
            unc_sev_reg <= unc_sev_next;
            cor_sts_reg <= cor_sts_next;
            cor_msk_reg <= cor_msk_next;
            rpt_fatal_reg <= |(unc_live & unc_sev_reg); // R13
            rpt_nonfatal_reg <= |(unc_live & ~unc_sev_reg); // R13
            rpt_corr_reg <= |cor_live; // R13
        end
    end

    assign rb.unc_sts = unc_sts_reg;
    assign rb.unc_msk = unc_msk_reg;
    assign rb.unc_sev = unc_sev_reg;
    assign rb.cor_sts = cor_sts_reg;
    assign rb.cor_msk = cor_msk_reg;
    assign rpt_fatal = rpt_fatal_reg;
    assign rpt_nonfatal = rpt_nonfatal_reg;
    assign rpt_corr = rpt_corr_reg;
endmodule
`default_nettype wire

// ==== dv/mer_regs_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module mer_regs_bench
    import mer_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic hot_rst = 1'b0;
    logic [1:0] htrans = 2'b00;
    logic [2:0] hsize = 3'b010;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [31:0] unc_err_evt = 32'h0000_0000;
    logic [31:0] cor_err_evt = 32'h0000_0000;
    wire hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic [63:0] msg_addr;
    logic [15:0] msg_data;
    logic rpt_fatal;
    logic rpt_nonfatal;
    logic rpt_corr;
    int n_fail = 0;
    int checks_done = 0;
    logic [31:0] q;
    logic [11:0] offs [9] = '{12'h0f4, 12'h0f8, 12'h0fc, 12'h100, 12'h104, 12'h108, 12'h10c,
        12'h110, 12'h114};
    logic [31:0] rst_v [9] = '{MER_ZERO, MER_ZERO, MER_ZERO, 32'h1501_0001, MER_ZERO, MER_ZERO,
        32'h0006_2011, MER_ZERO, 32'h0000_2000};
    // status words clear themselves when all ones are written back
    logic [31:0] ones_v [9] = '{32'hffff_fffc, 32'hffff_ffff, 32'h0000_ffff, 32'h1501_0001,
        MER_ZERO, 32'h001f_f011, 32'h001f_f011, MER_ZERO, 32'h0000_31c1};

    // single slave, so its ready is the bus ready
    assign hready = hreadyout;

    always #10 hclk = ~hclk;

    mer_regs u_dut (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hresp(hresp),
        .hrdata(hrdata),
        .hot_rst(hot_rst),
        .unc_err_evt(unc_err_evt),
        .cor_err_evt(cor_err_evt),
        .msg_addr(msg_addr),
        .msg_data(msg_data),
        .rpt_fatal(rpt_fatal),
        .rpt_nonfatal(rpt_nonfatal),
        .rpt_corr(rpt_corr)
    );

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // ready is sampled at the edge itself, before that edge's updates land
    task automatic wait_rdy;
        int i;
        logic ok;
        ok = 1'b0;
        for (i = 0; i < 16 && !ok; i++) begin
            @(posedge hclk);
            ok = (hreadyout === 1'b1);
        end
        if (!ok) begin
            n_fail++;
            $display("unexpected at %0t: bus never ready", $time);
            wrap_up();
        end
    endtask

    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {20'h0_0000, a};
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= MER_HSIZE_WORD;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        chk({31'h0, hresp}, MER_ZERO, "response not okay");
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
        bus(1'b0, a, MER_ZERO);
        chk(q, exp, what);
    endtask

    task automatic check_reset_vals;
        for (int k = 0; k < 9; k++) begin
            rd_chk(offs[k], rst_v[k], "value after reset");
        end
    endtask

    task automatic msg_chk(input logic [31:0] lo, input logic [31:0] hi, input logic [15:0] d);
        chk(msg_addr[31:0], lo, "message address low");
        chk(msg_addr[63:32], hi, "message address high");
        chk({16'h0000, msg_data}, {16'h0000, d}, "message payload");
    endtask

    // report pulse shows one cycle after the event cycle, then drops
    task automatic pulse(input logic [31:0] u, input logic [31:0] c, input logic [2:0] exp,
        input string what);
        @(posedge hclk);
        unc_err_evt <= u;
        cor_err_evt <= c;
        @(posedge hclk);
        unc_err_evt <= MER_ZERO;
        cor_err_evt <= MER_ZERO;
        #1;
        chk({29'h0, rpt_fatal, rpt_nonfatal, rpt_corr}, {29'h0, exp}, what);
        @(posedge hclk);
        #1;
        chk({29'h0, rpt_fatal, rpt_nonfatal, rpt_corr}, MER_ZERO, what);
    endtask

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        check_reset_vals();
        msg_chk(MER_ZERO, MER_ZERO, 16'h0000);
        $display("test reset values done");
        pulse(32'h0004_0000, MER_ZERO, 3'b100, "fatal report");
        pulse(32'h0000_1000, MER_ZERO, 3'b010, "non-fatal report");
        pulse(MER_ZERO, 32'h0000_0001, 3'b001, "correctable report");
        pulse(MER_ZERO, 32'h0000_2000, 3'b000, "advisory masked");
        pulse(32'hffe0_0fee, 32'hffff_ce3e, 3'b000, "unimplemented events");
        rd_chk(12'h104, 32'h0004_1000, "uncorrectable flags");
        rd_chk(12'h110, 32'h0000_2001, "correctable flags");
        wr(12'h104, 32'h0004_1000);
        rd_chk(12'h104, MER_ZERO, "flags after clear");
        wr(12'h108, 32'h0004_0000);
        pulse(32'h0004_0000, MER_ZERO, 3'b000, "masked fatal");
        rd_chk(12'h104, 32'h0004_0000, "masked flag still set");
        wr(12'h10c, MER_ZERO);
        pulse(32'h0000_0001, MER_ZERO, 3'b010, "severity lowered");
        $display("test error flags done");
        for (int k = 0; k < 9; k++) begin
            wr(offs[k], 32'hffff_ffff);
        end
        for (int k = 0; k < 9; k++) begin
            rd_chk(offs[k], ones_v[k], "all ones written");
        end
        msg_chk(32'hffff_fffc, 32'hffff_ffff, 16'hffff);
        wr(12'h118, 32'hffff_ffff);
        rd_chk(12'h118, MER_ZERO, "unmapped offset");
        $display("test write masks done");
        pulse(32'h0000_0010, MER_ZERO, 3'b000, "fully masked");
        @(posedge hclk);
        hot_rst <= 1'b1;
        @(posedge hclk);
        hot_rst <= 1'b0;
        rd_chk(12'h104, 32'h0000_0010, "flag kept over hot reset");
        rd_chk(12'h108, 32'h001f_f011, "mask kept over hot reset");
        rd_chk(12'h10c, 32'h001f_f011, "severity kept over hot reset");
        rd_chk(12'h114, 32'h0000_31c1, "correctable mask kept");
        rd_chk(12'h0f4, MER_ZERO, "message address cleared");
        msg_chk(MER_ZERO, MER_ZERO, 16'h0000);
        $display("test hot reset done");
        // a power-on reset mid-run must return every sticky bit to its reset value
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        check_reset_vals();
        $display("test power-on reset done");
        wrap_up();
    end
endmodule
`default_nettype wire
